// ---- rtl/cip_defines.svh ----
`ifndef CIP_DEFINES_SVH
`define CIP_DEFINES_SVH

// ************************************************************
// Timing
// ************************************************************
`define CIP_CLK_NS        10
`define CIP_STD_HALF_NS   5000
`define CIP_FMP_HALF_NS   500
`define CIP_STD_HALF_CYC  10'((`CIP_STD_HALF_NS + `CIP_CLK_NS - 1) / `CIP_CLK_NS)
`define CIP_FMP_HALF_CYC  10'((`CIP_FMP_HALF_NS + `CIP_CLK_NS - 1) / `CIP_CLK_NS)

// ************************************************************
// Register map
// ************************************************************
`define CIP_OFF_CMD       12'h000
`define CIP_OFF_STATUS    12'h004
`define CIP_OFF_DATA      12'h020
`define CIP_DATA_MASK     12'hFE0
`define CIP_CMD_GO        0
`define CIP_CMD_READ      1
`define CIP_CMD_ASEL      2
`define CIP_CMD_FAST      3
`define CIP_CMD_LEN_LSB   4
`define CIP_CMD_IDX_LSB   8
`define CIP_ST_BUSY       0
`define CIP_ST_DONE       1
`define CIP_ST_NACK       2
`define CIP_ST_BUSBUSY    3
`define CIP_CMD_RESET     32'h0000_0000

// ************************************************************
// Link
// ************************************************************
`define CIP_ADDR_LO       7'h74
`define CIP_ADDR_HI       7'h75
`define CIP_ACK_BIT       4'h8

`endif

// ---- rtl/cip_pkg.sv ----
`include "cip_defines.svh"

package cip_pkg;

  typedef enum logic [3:0] {
    CIP_S_IDLE   = 4'h0,
    CIP_S_STA_A  = 4'h1,
    CIP_S_STA_B  = 4'h2,
    CIP_S_STA_C  = 4'h3,
    CIP_S_BIT_LO = 4'h4,
    CIP_S_BIT_HI = 4'h5,
    CIP_S_STO_A  = 4'h6,
    CIP_S_STO_B  = 4'h7,
    CIP_S_STO_C  = 4'h8
  } cip_state_e;

  typedef enum logic [1:0] {
    CIP_G_ADDR  = 2'h0,
    CIP_G_INDEX = 2'h1,
    CIP_G_RADDR = 2'h2,
    CIP_G_DATA  = 2'h3
  } cip_stage_e;

  // Address byte: seven-bit target address, then direction (1 = read)
  function automatic logic [7:0] cip_addr_byte(input logic asel, input logic rd);
    cip_addr_byte = {(asel ? `CIP_ADDR_HI : `CIP_ADDR_LO), rd};
  endfunction

  function automatic logic cip_is_data(input logic [11:0] addr);
    cip_is_data = ((addr & `CIP_DATA_MASK) == `CIP_OFF_DATA) && (addr[1:0] == 2'h0);
  endfunction

endpackage

// ---- rtl/cip_sync2.sv ----
`timescale 1ns/1ps

// Two-stage synchroniser for the two link lines
module cip_sync2 (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] d,
  output logic      [1:0] q
);

  logic [1:0] meta;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 2'h3;
      q    <= 2'h3;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// ---- rtl/cip_half_timer.sv ----
`timescale 1ns/1ps

// Counts one half period of the serial clock
module cip_half_timer (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       restart,
  input  wire logic [9:0] limit,
  output logic            expired
);

  logic [9:0] cnt;
  logic [9:0] next_cnt;

  assign expired = (cnt == 10'(limit - 10'h001));

  always_comb begin
    if (restart) begin
      next_cnt = 10'h000;
    end else if (expired) begin
      next_cnt = cnt;
    end else begin
      next_cnt = 10'(cnt + 10'h001);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 10'h000;
    end else begin
      cnt <= next_cnt;
    end
  end

endmodule

// ---- rtl/cip_host.sv ----
`timescale 1ns/1ps
`include "cip_defines.svh"

module cip_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  // ************************************************************
  // State
  // ************************************************************
  cip_pkg::cip_state_e state;
  cip_pkg::cip_state_e next_state;
  cip_pkg::cip_stage_e stage;
  cip_pkg::cip_stage_e next_stage;
  logic [7:0]          mem [0:7];
  logic [7:0]          next_mem [0:7];
  logic [7:0]          shift;
  logic [7:0]          next_shift;
  logic [3:0]          bit_cnt;
  logic [3:0]          next_bit_cnt;
  logic [2:0]          byte_cnt;
  logic [2:0]          next_byte_cnt;
  logic                cmd_rd;
  logic                next_cmd_rd;
  logic                cmd_asel;
  logic                next_cmd_asel;
  logic                cmd_fast;
  logic                next_cmd_fast;
  logic [2:0]          cmd_len;
  logic [2:0]          next_cmd_len;
  logic [7:0]          cmd_idx;
  logic [7:0]          next_cmd_idx;
  logic [9:0]          half_cyc;
  logic [9:0]          next_half_cyc;
  logic                rep;
  logic                next_rep;
  logic                done;
  logic                next_done;
  logic                nack;
  logic                next_nack;
  logic                bus_busy;
  logic                next_bus_busy;
  logic                scl_prev;
  logic                sda_prev;
  logic                next_scl_oe;
  logic                next_sda_oe;
  logic [31:0]         next_prdata;
  logic                next_pslverr;
  logic                tmr_restart;
  logic                expired;
  logic [1:0]          line_s;
  logic                scl_s;
  logic                sda_s;
  logic                wr_acc;
  logic                setup;
  logic                mapped;
  logic                go;
  logic                rx_mode;

  assign scl_o   = 1'b0;
  assign sda_o   = 1'b0;
  assign pready  = 1'b1;
  assign scl_s   = line_s[1];
  assign sda_s   = line_s[0];
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pwrite;
  assign mapped  = (paddr == `CIP_OFF_CMD) || (paddr == `CIP_OFF_STATUS) || cip_pkg::cip_is_data(paddr);
  assign rx_mode = cmd_rd && (stage == cip_pkg::CIP_G_DATA);
  // New command only when idle and nobody else holds the bus
  assign go      = wr_acc && (paddr == `CIP_OFF_CMD) && pwdata[`CIP_CMD_GO]
                   && (state == cip_pkg::CIP_S_IDLE) && !bus_busy;

  cip_sync2 u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({scl_i, sda_i}),
    .q       (line_s)
  );

  cip_half_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (tmr_restart),
    .limit   (half_cyc),
    .expired (expired)
  );

  // ************************************************************
  // Next values
  // ************************************************************
  always_comb begin
    next_state    = state;
    next_stage    = stage;
    next_mem      = mem;
    next_shift    = shift;
    next_bit_cnt  = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_cmd_rd   = cmd_rd;
    next_cmd_asel = cmd_asel;
    next_cmd_fast = cmd_fast;
    next_cmd_len  = cmd_len;
    next_cmd_idx  = cmd_idx;
    next_half_cyc = half_cyc;
    next_rep      = rep;
    next_done     = done;
    next_nack     = nack;
    next_scl_oe   = scl_oe;
    next_sda_oe   = sda_oe;
    next_prdata   = prdata;
    next_pslverr  = 1'b0;

    next_bus_busy = bus_busy;
    if (scl_s && scl_prev && sda_prev && !sda_s) begin
      next_bus_busy = 1'b1;
    end else if (scl_s && scl_prev && !sda_prev && sda_s) begin
      next_bus_busy = 1'b0;
    end

    // Register access; sticky flags clear by writing one
    if (setup) begin
      next_pslverr = !mapped;
      if (paddr == `CIP_OFF_CMD) begin
        next_prdata = {16'h0000, cmd_idx, 1'b0, cmd_len, cmd_fast, cmd_asel, cmd_rd, 1'b0};
      end else if (paddr == `CIP_OFF_STATUS) begin
        next_prdata = {28'h000_0000, bus_busy, nack, done, (state != cip_pkg::CIP_S_IDLE)};
      end else if (cip_pkg::cip_is_data(paddr)) begin
        next_prdata = {24'h00_0000, mem[paddr[4:2]]};
      end else begin
        next_prdata = 32'h0000_0000;
      end
    end
    if (wr_acc && (paddr == `CIP_OFF_STATUS)) begin
      if (pwdata[`CIP_ST_DONE]) begin
        next_done = 1'b0;
      end
      if (pwdata[`CIP_ST_NACK]) begin
        next_nack = 1'b0;
      end
    end
    if (wr_acc && cip_pkg::cip_is_data(paddr) && (state == cip_pkg::CIP_S_IDLE)) begin
      next_mem[paddr[4:2]] = pwdata[7:0];
    end
    // a command written while busy or while the bus is held is dropped, not queued
    if (go) begin
      next_cmd_rd   = pwdata[`CIP_CMD_READ];
      next_cmd_asel = pwdata[`CIP_CMD_ASEL];
      next_cmd_fast = pwdata[`CIP_CMD_FAST];
      next_cmd_len  = pwdata[`CIP_CMD_LEN_LSB +: 3];
      next_cmd_idx  = pwdata[`CIP_CMD_IDX_LSB +: 8];
      next_half_cyc = pwdata[`CIP_CMD_FAST] ? `CIP_FMP_HALF_CYC : `CIP_STD_HALF_CYC;
      next_rep      = 1'b0;
      next_stage    = cip_pkg::CIP_G_ADDR;
      next_byte_cnt = 3'h0;
      next_state    = cip_pkg::CIP_S_STA_A;
    end

    case (state)
      cip_pkg::CIP_S_IDLE: begin
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
      end
      cip_pkg::CIP_S_STA_A: begin
        // Repeated start keeps SCL low while SDA is released
        next_sda_oe = 1'b0;
        if (expired) begin
          next_scl_oe = 1'b0;
          next_state  = cip_pkg::CIP_S_STA_B;
        end
      end
      cip_pkg::CIP_S_STA_B: begin
        if (expired && scl_s) begin
          next_sda_oe = 1'b1;
          next_state  = cip_pkg::CIP_S_STA_C;
        end
      end
      cip_pkg::CIP_S_STA_C: begin
        if (expired) begin
          next_scl_oe  = 1'b1;
          next_bit_cnt = 4'h0;
          next_shift   = cip_pkg::cip_addr_byte(cmd_asel, rep);
          next_state   = cip_pkg::CIP_S_BIT_LO;
        end
      end
      cip_pkg::CIP_S_BIT_LO: begin
        // SDA moves one cycle after SCL has fallen
        // ninth clock: transmitter releases, receiver acknowledges all but the last read byte
        if (bit_cnt == `CIP_ACK_BIT) begin
          next_sda_oe = rx_mode && (byte_cnt != cmd_len);
        end else begin
          next_sda_oe = !rx_mode && !shift[7];
        end
        if (expired) begin
          next_scl_oe = 1'b0;
          next_state  = cip_pkg::CIP_S_BIT_HI;
        end
      end
      cip_pkg::CIP_S_BIT_HI: begin
        // high phase counts only once SCL is really high
        if (expired && scl_s) begin
          next_scl_oe = 1'b1;
          next_state  = cip_pkg::CIP_S_BIT_LO;
          if (bit_cnt != `CIP_ACK_BIT) begin
            next_shift   = {shift[6:0], sda_s};
            next_bit_cnt = 4'(bit_cnt + 4'h1);
          end else begin
            next_bit_cnt = 4'h0;
            if (rx_mode) begin
              next_mem[byte_cnt] = shift;
              next_byte_cnt      = 3'(byte_cnt + 3'h1);
              // last byte was not acknowledged; finish with stop
              if (byte_cnt == cmd_len) begin
                next_state = cip_pkg::CIP_S_STO_A;
              end
            end else if (sda_s) begin
              next_nack  = 1'b1;
              next_state = cip_pkg::CIP_S_STO_A;
            end else begin
              case (stage)
                cip_pkg::CIP_G_ADDR: begin
                  next_stage = cip_pkg::CIP_G_INDEX;
                  next_shift = cmd_idx;
                end
                cip_pkg::CIP_G_INDEX: begin
                  next_stage = cmd_rd ? cip_pkg::CIP_G_RADDR : cip_pkg::CIP_G_DATA;
                  next_shift = mem[0];
                  if (cmd_rd) begin
                    next_rep   = 1'b1;
                    next_state = cip_pkg::CIP_S_STA_A;
                  end
                end
                cip_pkg::CIP_G_RADDR: begin
                  next_stage = cip_pkg::CIP_G_DATA;
                end
                cip_pkg::CIP_G_DATA: begin
                  next_byte_cnt = 3'(byte_cnt + 3'h1);
                  next_shift    = mem[3'(byte_cnt + 3'h1)];
                  if (byte_cnt == cmd_len) begin
                    next_state = cip_pkg::CIP_S_STO_A;
                  end
                end
                default: begin
                  next_state = cip_pkg::CIP_S_STO_A;
                end
              endcase
            end
          end
        end
      end
      cip_pkg::CIP_S_STO_A: begin
        next_sda_oe = 1'b1;
        if (expired) begin
          next_scl_oe = 1'b0;
          next_state  = cip_pkg::CIP_S_STO_B;
        end
      end
      cip_pkg::CIP_S_STO_B: begin
        // SDA rises while SCL high: bus free
        if (expired && scl_s) begin
          next_sda_oe = 1'b0;
          next_state  = cip_pkg::CIP_S_STO_C;
        end
      end
      cip_pkg::CIP_S_STO_C: begin
        if (expired) begin
          next_done  = 1'b1;
          next_state = cip_pkg::CIP_S_IDLE;
        end
      end
      default: begin
        next_scl_oe = 1'b0;
        next_sda_oe = 1'b0;
        next_state  = cip_pkg::CIP_S_IDLE;
      end
    endcase

    // Stretching holds the timer at zero until SCL is seen high
    tmr_restart = (next_state != state) || (!scl_s && ((state == cip_pkg::CIP_S_STA_B)
                  || (state == cip_pkg::CIP_S_BIT_HI) || (state == cip_pkg::CIP_S_STO_B)));
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= cip_pkg::CIP_S_IDLE;
      stage    <= cip_pkg::CIP_G_ADDR;
      for (int i = 0; i < 8; i++) begin
        mem[i] <= 8'h00;
      end
      shift    <= 8'h00;
      bit_cnt  <= 4'h0;
      byte_cnt <= 3'h0;
      cmd_rd   <= 1'b0;
      cmd_asel <= 1'b0;
      cmd_fast <= 1'b0;
      cmd_len  <= 3'h0;
      cmd_idx  <= 8'h00;
      half_cyc <= `CIP_STD_HALF_CYC;
      rep      <= 1'b0;
      done     <= 1'b0;
      nack     <= 1'b0;
      bus_busy <= 1'b0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      scl_oe   <= 1'b0;
      sda_oe   <= 1'b0;
      prdata   <= `CIP_CMD_RESET;
      pslverr  <= 1'b0;
    end else begin
      state    <= next_state;
      stage    <= next_stage;
      mem      <= next_mem;
      shift    <= next_shift;
      bit_cnt  <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      cmd_rd   <= next_cmd_rd;
      cmd_asel <= next_cmd_asel;
      cmd_fast <= next_cmd_fast;
      cmd_len  <= next_cmd_len;
      cmd_idx  <= next_cmd_idx;
      half_cyc <= next_half_cyc;
      rep      <= next_rep;
      done     <= next_done;
      nack     <= next_nack;
      bus_busy <= next_bus_busy;
      scl_prev <= scl_s;
      sda_prev <= sda_s;
      scl_oe   <= next_scl_oe;
      sda_oe   <= next_sda_oe;
      prdata   <= next_prdata;
      pslverr  <= next_pslverr;
    end
  end

endmodule

// ---- tb/cip_host_properties.sv ----
`timescale 1ns/1ps
`include "cip_defines.svh"

// ************************************************************
// Link and bus checker
// ************************************************************
module cip_host_checker (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  input  wire logic        scl_i,
  input  wire logic        scl_oe,
  input  wire logic        sda_i,
  input  wire logic        sda_oe
);
  logic        scl_q;
  logic        sda_q;
  logic        busy;
  logic        pend;
  logic [6:0]  sh;
  logic [15:0] cnt;
  logic [15:0] hcnt;
  logic [15:0] wcnt;
  wire logic   rise     = !scl_q && scl_i;
  wire logic   start_ev = sda_q && !sda_i && scl_q && scl_i;
  wire logic   stop_ev  = !sda_q && sda_i && scl_q && scl_i;
  wire logic   nack_ev  = rise && busy && (cnt % 16'd9 == 16'd8) && sda_i && !sda_oe;
  wire logic   mapped   = paddr == 12'h000 || paddr == 12'h004 || (paddr[11:5] == 7'h01 && paddr[1:0] == 2'h0);

  // Wire levels are sampled raw, so counts lead the design by the synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      busy  <= 1'b0;
      pend  <= 1'b0;
      sh    <= 7'h0;
      cnt   <= 16'h0;
      hcnt  <= 16'h0;
      wcnt  <= 16'h0;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
      busy  <= start_ev || (busy && !stop_ev);
      pend  <= nack_ev || (pend && !stop_ev && !start_ev);
      wcnt  <= pend ? wcnt + 16'd1 : 16'h0;
      hcnt  <= (scl_i && !scl_oe) ? ((hcnt == 16'hFFFF) ? hcnt : hcnt + 16'd1) : 16'h0;
      cnt   <= start_ev ? 16'h0 : (rise ? cnt + 16'd1 : cnt);
      sh    <= rise ? {sh[5:0], sda_i} : sh;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_unmapped_err: assert property (psel && !penable && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && !penable && mapped |=> !pslverr)
    else $error("mapped access refused");
  a_start_shape: assert property ($rose(sda_oe) && !scl_oe |-> scl_i ##1 (!scl_oe) [*8])
    else $error("start not taken with clock high");
  a_stop_shape: assert property ($fell(sda_oe) && !scl_oe |-> scl_i ##1 (!scl_oe && !sda_oe) [*8])
    else $error("stop not followed by idle bus");
  a_stretch_wait: assert property (!scl_oe && !scl_i && !$past(scl_oe) |=> !scl_oe)
    else $error("clock pulled while target held it");
  a_rate_limit: assert property ($rose(scl_oe) |-> hcnt >= 16'(`CIP_FMP_HALF_CYC))
    else $error("clock high phase too short");
  a_nine_clocks: assert property (busy && (start_ev || stop_ev) |-> cnt % 16'd9 == 16'd1)
    else $error("frame ended off a byte boundary");
  a_addr_byte: assert property (busy && rise && cnt == 16'd7 |-> sh inside {7'h74, 7'h75})
    else $error("first byte holds a foreign address");
  a_nack_bound: assert property (pend |-> wcnt < 16'd2000)
    else $error("no stop soon after not-acknowledge");
  a_nack_no_data: assert property (pend && rise |-> cnt % 16'd9 == 16'd0)
    else $error("data clocked after not-acknowledge");

  cover property (nack_ev);
  cover property (busy && start_ev);
  cover property (!scl_oe && !scl_i ##1 !scl_oe && !scl_i);
endmodule

bind cip_host cip_host_checker cip_host_checker_inst (
  .pclk    (pclk),
  .presetn (presetn),
  .paddr   (paddr),
  .psel    (psel),
  .penable (penable),
  .prdata  (prdata),
  .pslverr (pslverr),
  .scl_i   (scl_i),
  .scl_oe  (scl_oe),
  .sda_i   (sda_i),
  .sda_oe  (sda_oe)
);

// ---- tb/cip_target_model.sv ----
`timescale 1ns/1ps

// ************************************************************
// Converter register target
// ************************************************************
module cip_target_model #(
  parameter logic [6:0] TARGET_ADDR = 7'h74
) (
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic [15:0] stretch_ns,
  output logic             scl_pull,
  output logic             sda_pull,
  output logic [9:0]       ref_code,
  output logic             limit_on
);
  logic [7:0] regs [0:7];
  logic [7:0] ptr;
  assign limit_on = regs[2][7];

  // sense target, fixed step per code
  localparam int STEP_UV       = 500;
  // retry timing; mode bit positions are arbitrary here
  localparam int HICCUP_OFF_MS = 76;
  localparam int SOFT_START_MS = 4;
  localparam int HICCUP_BIT    = 0;
  localparam int PSKIP_BIT     = 1;
  localparam logic MODE_PIN_SKIP = 1'b0;
  int         sense_uv;
  int         restart_ms;
  int         soft_starts = 0;
  logic       hiccup_on;
  logic       pulse_skip_light_load;
  assign sense_uv = limit_on ? STEP_UV * int'(regs[2][6:0]) : 0;
  assign hiccup_on = regs[6][HICCUP_BIT];
  // off interval then soft start, only with hiccup on
  assign restart_ms = hiccup_on ? HICCUP_OFF_MS + SOFT_START_MS : 0;
  // pin choice or register bit, else fixed frequency
  assign pulse_skip_light_load = MODE_PIN_SKIP || regs[6][PSKIP_BIT];

  // thermal trip reruns soft start, registers kept
  task automatic thermal_trip();
    soft_starts++;
  endtask

  task automatic rx(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      b = {b[6:0], sda};
    end
    @(negedge scl);
  endtask

  task automatic ack();
    sda_pull = 1'b1;
    if (stretch_ns != 16'h0) begin
      scl_pull = 1'b1;
      #(stretch_ns);
      scl_pull = 1'b0;
    end
    @(negedge scl);
    sda_pull = 1'b0;
  endtask

  task automatic tx(input logic [7:0] b, output logic acked);
    for (int i = 7; i >= 0; i--) begin
      sda_pull = ~b[i];
      @(negedge scl);
    end
    sda_pull = 1'b0;
    @(posedge scl);
    acked = (sda === 1'b0);
    @(negedge scl);
  endtask

  task automatic xfer();
    logic [7:0] b;
    logic       ok;
    @(negedge scl);
    rx(b);
    if (b[7:1] != TARGET_ADDR) wait (1'b0);
    ack();
    if (b[0]) begin
      forever begin
        tx((ptr < 8'd8) ? regs[ptr[2:0]] : 8'hFF, ok);
        ptr = ptr + 8'd1;
        if (!ok) wait (1'b0);
      end
    end
    rx(b);
    if (b > 8'd7) wait (1'b0);
    ptr = b;
    ack();
    forever begin
      rx(b);
      if (ptr > 8'd7) wait (1'b0);
      regs[ptr[2:0]] = b;
      if (ptr == 8'd1) ref_code = {regs[1][1:0], regs[0]};
      ptr = ptr + 8'd1;
      ack();
    end
  endtask

  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    ptr = 8'h0;
    regs = '{8'hD2, 8'h00, 8'hE4, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    ref_code = 10'h0D2;
    forever begin
      @(negedge sda iff scl === 1'b1);
      do begin
        fork
          xfer();
          @(sda iff scl === 1'b1);
        join_any
        disable fork;
        sda_pull = 1'b0;
        scl_pull = 1'b0;
      end while (sda === 1'b0);
    end
  end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
`include "cip_defines.svh"

// ************************************************************
// Top bench
// ************************************************************
module testbench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl_oe;
  logic        sda_oe;
  logic        t74_scl;
  logic        t74_sda;
  logic        t75_scl;
  logic        t75_sda;
  logic [15:0] st75 = 16'h0;
  logic [9:0]  ref74;
  logic        lim74;
  wire logic   scl_line = ~(scl_oe | t74_scl | t75_scl);
  wire logic   sda_line = ~(sda_oe | t74_sda | t75_sda);
  int          n_fail = 0;
  int          total_checks = 0;
  int          cyc = 0;
  logic [7:0]  exp_reg [0:1][0:7];
  logic [31:0] rd;
  logic [31:0] st;
  logic        err;

  always #5 pclk = ~pclk;

  cip_host cip_host_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_line),
    .scl_o(), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe));
  cip_target_model #(.TARGET_ADDR(7'h74)) target74_inst (.scl(scl_line), .sda(sda_line), .stretch_ns(16'h0),
    .scl_pull(t74_scl), .sda_pull(t74_sda), .ref_code(ref74), .limit_on(lim74));
  cip_target_model #(.TARGET_ADDR(7'h75)) target75_inst (.scl(scl_line), .sda(sda_line), .stretch_ns(st75),
    .scl_pull(t75_scl), .sda_pull(t75_sda), .ref_code(), .limit_on());

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Polls done, then clears both sticky flags so the next transfer starts clean
  task automatic xfer(input logic asel, input logic rdir, input logic fast, input logic [2:0] len,
                      input logic [7:0] idx);
    bus(`CIP_OFF_CMD, 1'b1, {16'h0, idx, 1'b0, len, fast, asel, rdir, 1'b1});
    bus(`CIP_OFF_STATUS, 1'b0, 32'h0);
    chk("engine busy", 32'h1, {31'h0, rd[`CIP_ST_BUSY]});
    do bus(`CIP_OFF_STATUS, 1'b0, 32'h0); while (rd[1] !== 1'b1);
    st = rd;
    bus(`CIP_OFF_STATUS, 1'b1, 32'h0000_0006);
  endtask

  task automatic wr_seq(input logic asel, input logic fast, input logic [7:0] idx, input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom);
      exp_reg[asel][idx + i] = b;
      bus(`CIP_OFF_DATA + 12'(4 * i), 1'b1, {24'h0, b});
    end
    xfer(asel, 1'b0, fast, 3'(n - 1), idx);
    chk("write nack", 32'h0, {31'h0, st[2]});
  endtask

  task automatic rd_seq(input logic asel, input logic [7:0] idx, input int n);
    xfer(asel, 1'b1, 1'b1, 3'(n - 1), idx);
    chk("read nack", 32'h0, {31'h0, st[2]});
    for (int i = 0; i < n; i++) begin
      bus(`CIP_OFF_DATA + 12'(4 * i), 1'b0, 32'h0);
      chk("read byte", {24'h0, exp_reg[asel][idx + i]}, rd);
    end
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(32'h60fe));
    exp_reg[0] = '{8'hD2, 8'h00, 8'hE4, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    exp_reg[1] = exp_reg[0];
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    st75 <= 16'd3000;
    bus(`CIP_OFF_CMD, 1'b0, 32'h0);
    chk("cmd reset", `CIP_CMD_RESET, rd);
    bus(`CIP_OFF_STATUS, 1'b0, 32'h0);
    chk("status reset", 32'h0, rd);
    bus(12'h040, 1'b0, 32'h0);
    chk("unmapped read", 32'h1, {31'h0, err});
    bus(12'h010, 1'b1, 32'hFFFF_FFFF);
    chk("unmapped write", 32'h1, {31'h0, err});
    xfer(1'b0, 1'b0, 1'b1, 3'h0, 8'h08);
    chk("undefined index", 32'h1, {31'h0, st[2]});
    // Second target stretches every acknowledge it sends
    for (int a = 0; a < 2; a++) begin
      wr_seq(1'(a), 1'b1, 8'h04, 4);
      rd_seq(1'(a), 8'h04, 4);
    end
    wr_seq(1'b0, 1'b0, 8'h00, 1);
    chk("low byte only", 32'h0D2, {22'h0, ref74});
    wr_seq(1'b0, 1'b1, 8'h01, 2);
    chk("ref load", {22'h0, exp_reg[0][1][1:0], exp_reg[0][0]}, {22'h0, ref74});
    chk("limit enable", {31'h0, exp_reg[0][2][7]}, {31'h0, lim74});
    chk("sense target", exp_reg[0][2][7] ? 500 * exp_reg[0][2][6:0] : 0, target74_inst.sense_uv);
    chk("hiccup retry ms", exp_reg[0][6][0] ? 76 + 4 : 0, target74_inst.restart_ms);
    chk("light load skip", {31'h0, exp_reg[0][6][1]}, {31'h0, target74_inst.pulse_skip_light_load});
    target74_inst.thermal_trip();
    chk("soft start rerun", 32'h1, target74_inst.soft_starts);
    rd_seq(1'b0, 8'h00, 3);
    give_verdict();
  end
endmodule
